// file: common/hfs_pkg.sv
`default_nettype none
package hfs_pkg;
    // clock and bus widths
    localparam int CLK_NS = 100;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int PULSE_W = 17;

    // program and erase durations, polling starts after the typical time
    localparam int PROG_BYTE_US = 9;
    localparam int PROG_WORD_US = 11;
    localparam int PROG_BYTE_CYC = PROG_BYTE_US * 1000 / CLK_NS;
    localparam int PROG_WORD_CYC = PROG_WORD_US * 1000 / CLK_NS;
    localparam real SECTOR_ERASE_S = 0.7;
    localparam int SECTOR_ERASE_CYC = int'(SECTOR_ERASE_S * 1.0e9 / CLK_NS);

    // reset pin timing
    localparam int RST_PULSE_NS = 500;
    localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RST_ACTIVE_US = 20;
    localparam int RST_ACTIVE_CYC = RST_ACTIVE_US * 1000 / CLK_NS;
    localparam int RST_IDLE_NS = 500;
    localparam int RST_IDLE_CYC = RST_IDLE_NS / CLK_NS;
    localparam int RST_HIGH_NS = 50;
    localparam int RST_HIGH_CYC = (RST_HIGH_NS + CLK_NS - 1) / CLK_NS;

    // protect and unprotect pulse timing
    localparam int PROT_PULSE_MIN_NS = 100;
    localparam int PROT_PULSE_MIN_CYC = (PROT_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int PROT_PULSE_US = 10;
    localparam int PROT_PULSE_CYC = PROT_PULSE_US * 1000 / CLK_NS;
    localparam int UNPROT_PULSE_MS = 12;
    localparam int UNPROT_PULSE_CYC = UNPROT_PULSE_MS * 1000000 / CLK_NS;
    localparam int OE_SETUP_US = 4;
    localparam int OE_SETUP_CYC = OE_SETUP_US * 1000 / CLK_NS;

    // read access
    localparam int READ_ACCESS_NS = 70;
    localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS;

    // sector select field of the address
    localparam int SECTOR_LSB = 12;
    localparam int SECTOR_W = 7;

    // command write codes
    localparam logic [ADDR_W-1:0] UNLOCK1_WORD = 20'h00555;
    localparam logic [ADDR_W-1:0] UNLOCK2_WORD = 20'h002AA;
    localparam logic [ADDR_W-1:0] UNLOCK1_BYTE = 20'h00AAA;
    localparam logic [ADDR_W-1:0] UNLOCK2_BYTE = 20'h00555;
    localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 16'h00AA;
    localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 16'h0055;
    localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h00A0;
    localparam logic [DATA_W-1:0] CMD_ERASE = 16'h0080;
    localparam logic [DATA_W-1:0] CMD_CHIP = 16'h0010;
    localparam logic [DATA_W-1:0] CMD_SECTOR = 16'h0030;

    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_PROGRAM = 3'h1,
        OP_CHIP_ERASE = 3'h2,
        OP_SECTOR_ERASE = 3'h3,
        OP_PROTECT = 3'h4,
        OP_UNPROTECT = 3'h5,
        OP_RESET = 3'h6
    } hfs_op_t;

    typedef struct packed {
        hfs_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic wordMode;
        logic useToggle;
    } hfs_cmd_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic timeout;
    } hfs_rsp_t;

    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } hfs_cyc_t;

    typedef struct packed {
        logic ceB;
        logic oeB;
        logic weB;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dOut;
        logic dOe;
    } hfs_bus_t;

    typedef struct packed {
        hfs_bus_t bus;
        logic resetB;
        logic byteB;
    } hfs_pins_t;
endpackage
`default_nettype wire

// file: hw/hfs_bus_cycle.sv
`timescale 1ns/1ps
`default_nettype none
module hfs_bus_cycle
    import hfs_pkg::*;
#(
    parameter int PW = PULSE_W
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic start,
    input wire hfs_cyc_t cyc,
    input wire logic [7:0] setupLen,
    input wire logic [PW-1:0] pulseLen,
    input wire logic [DATA_W-1:0] dataIn,
    output logic busy,
    output logic done_r,
    output logic [DATA_W-1:0] rdData_r,
    output hfs_bus_t bus_r
);
    typedef enum logic [3:0] {
        E_IDLE = 4'b0001,
        E_SETUP = 4'b0010,
        E_PULSE = 4'b0100,
        E_HOLD = 4'b1000
    } hfs_est_t;

    hfs_est_t st_r, st_nxt;
    logic [PW-1:0] cnt_r, cnt_nxt;
    logic wr_r, wr_nxt;
    logic done_nxt;
    logic [DATA_W-1:0] rd_nxt;
    hfs_bus_t bus_nxt;

    assign busy = (st_r != E_IDLE);

    // one write or read cycle: chip select, setup, strobe, release
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        wr_nxt = wr_r;
        bus_nxt = bus_r;
        rd_nxt = rdData_r;
        done_nxt = 1'b0;
        unique case (st_r)
            E_IDLE: begin
                if (start) begin
                    st_nxt = E_SETUP;
                    cnt_nxt = PW'(setupLen);
                    wr_nxt = cyc.write;
                    bus_nxt.ceB = 1'b0;
                    bus_nxt.addr = cyc.addr;
                    bus_nxt.dOut = cyc.data;
                    bus_nxt.dOe = cyc.write;
                end
            end
            E_SETUP: begin
                if (cnt_r <= PW'(1)) begin
                    st_nxt = E_PULSE;
                    cnt_nxt = pulseLen;
                    bus_nxt.weB = !wr_r;
                    bus_nxt.oeB = wr_r;
                end else begin
                    cnt_nxt = cnt_r - PW'(1);
                end
            end
            E_PULSE: begin
                if (cnt_r <= PW'(1)) begin
                    st_nxt = E_HOLD;
                    bus_nxt.weB = 1'b1;
                    bus_nxt.oeB = 1'b1;
                    if (!wr_r) begin
                        rd_nxt = dataIn; // sampled a full period after output enable
                    end
                end else begin
                    cnt_nxt = cnt_r - PW'(1);
                end
            end
            E_HOLD: begin
                st_nxt = E_IDLE;
                bus_nxt.ceB = 1'b1;
                bus_nxt.dOe = 1'b0;
                done_nxt = 1'b1;
            end
        endcase
    end

    // cycle state registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= E_IDLE;
            cnt_r <= '0;
            wr_r <= 1'b0;
            done_r <= 1'b0;
            rdData_r <= '0;
            bus_r <= '{ceB: 1'b1, oeB: 1'b1, weB: 1'b1, addr: '0, dOut: '0, dOe: 1'b0};
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            wr_r <= wr_nxt;
            done_r <= done_nxt;
            rdData_r <= rd_nxt;
            bus_r <= bus_nxt;
        end
    end
endmodule
`default_nettype wire

// file: hw/hfs_host_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module hfs_host_ctrl
    import hfs_pkg::*;
#(
    parameter int ERASE_WAIT_CYC = SECTOR_ERASE_CYC,
    parameter int UNPROT_CYC = UNPROT_PULSE_CYC,
    parameter int TIMEOUT_CYC = 200000000
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire hfs_cmd_t cmdIn,
    output logic rspValid_r,
    output hfs_rsp_t rsp_r,
    output logic busy,
    output hfs_pins_t flashPins,
    input wire logic [DATA_W-1:0] flashDataIn
);
    typedef enum logic [5:0] {
        S_RLOW = 6'b000001,
        S_RWAIT = 6'b000010,
        S_IDLE = 6'b000100,
        S_SEQ = 6'b001000,
        S_ALG = 6'b010000,
        S_POLL = 6'b100000
    } hfs_st_t;

    hfs_st_t st_r, st_nxt;
    hfs_cmd_t cmd_r, cmd_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic [31:0] to_r, to_nxt;
    logic [2:0] step_r, step_nxt;
    logic pend_r, pend_nxt;
    logic alg_r, alg_nxt;
    logic prevQ6_r, prevQ6_nxt;
    logic havePrev_r, havePrev_nxt;
    logic resetB_r, resetB_nxt;
    logic byteB_r, byteB_nxt;
    logic rspValid_nxt;
    hfs_rsp_t rsp_nxt;
    logic cycStart, cycBusy, cycDone;
    hfs_cyc_t cycReq;
    logic [7:0] setupLen;
    logic [PULSE_W-1:0] pulseLen;
    logic [DATA_W-1:0] rdData;
    hfs_bus_t busPins;
    logic resetAccept, expect7, pollDone;

    // index of the last bus cycle of each command sequence
    function automatic logic [2:0] lastStep(input hfs_op_t op);
        unique case (op)
            OP_PROGRAM: lastStep = 3'h3;
            OP_CHIP_ERASE, OP_SECTOR_ERASE: lastStep = 3'h5;
            default: lastStep = 3'h0;
        endcase
    endfunction

    // bus cycle for a given step of a command sequence
    function automatic hfs_cyc_t seqCycle(input hfs_cmd_t c, input logic [2:0] s);
        logic [ADDR_W-1:0] a1;
        logic [ADDR_W-1:0] a2;
        a1 = c.wordMode ? UNLOCK1_WORD : UNLOCK1_BYTE;
        a2 = c.wordMode ? UNLOCK2_WORD : UNLOCK2_BYTE;
        seqCycle = '{write: 1'b1, addr: a1, data: UNLOCK_DATA1};
        if (c.op == OP_READ) begin
            seqCycle = '{write: 1'b0, addr: c.addr, data: '0};
        end else if (c.op == OP_PROTECT || c.op == OP_UNPROTECT) begin
            seqCycle = '{write: 1'b1, addr: c.addr, data: c.data};
        end else if (s == 3'h1 || s == 3'h4) begin
            seqCycle = '{write: 1'b1, addr: a2, data: UNLOCK_DATA2};
        end else if (s == 3'h2) begin
            seqCycle.data = (c.op == OP_PROGRAM) ? CMD_PROGRAM : CMD_ERASE;
        end else if (s == 3'h3 && c.op == OP_PROGRAM) begin
            seqCycle = '{write: 1'b1, addr: c.addr, data: c.data};
        end else if (s == 3'h5 && c.op == OP_SECTOR_ERASE) begin
            seqCycle.addr = c.addr & ~ADDR_W'((1 << SECTOR_LSB) - 1);
            seqCycle.data = CMD_SECTOR;
        end else if (s == 3'h5) begin
            seqCycle.data = CMD_CHIP;
        end
    endfunction

    // request to the cycle engine and its strobe timing
    always_comb begin
        cycReq = (st_r == S_POLL) ? '{write: 1'b0, addr: cmd_r.addr, data: '0}
                                  : seqCycle(cmd_r, step_r);
        setupLen = 8'h01;
        pulseLen = cycReq.write ? PULSE_W'(1) : PULSE_W'(READ_ACCESS_CYC);
        if (st_r == S_SEQ && cmd_r.op == OP_PROTECT) begin
            setupLen = 8'(OE_SETUP_CYC);
            pulseLen = PULSE_W'(PROT_PULSE_CYC);
        end else if (st_r == S_SEQ && cmd_r.op == OP_UNPROTECT) begin
            setupLen = 8'(OE_SETUP_CYC);
            pulseLen = PULSE_W'(UNPROT_CYC);
        end
    end

    hfs_bus_cycle #(
        .PW(PULSE_W)
    ) u_cycle (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .start(cycStart),
        .cyc(cycReq),
        .setupLen(setupLen),
        .pulseLen(pulseLen),
        .dataIn(flashDataIn),
        .busy(cycBusy),
        .done_r(cycDone),
        .rdData_r(rdData),
        .bus_r(busPins)
    );

    assign flashPins = '{bus: busPins, resetB: resetB_r, byteB: byteB_r};
    assign busy = (st_r != S_IDLE);
    // an abort reset is only taken in the algorithm wait or status polling, with no bus cycle pending
    assign resetAccept = cmdValid && cmdIn.op == OP_RESET && !pend_r && !cycBusy
                         && (st_r == S_ALG || st_r == S_POLL);
    assign cmdReady = (st_r == S_IDLE) || resetAccept;
    // completion test: true data on bit 7, or bit 6 stops toggling
    assign expect7 = (cmd_r.op == OP_PROGRAM) ? cmd_r.data[7] : 1'b1;
    assign pollDone = cmd_r.useToggle ? (havePrev_r && rdData[6] == prevQ6_r)
                                      : (rdData[7] == expect7);
    assign cycStart = (st_r == S_SEQ || st_r == S_POLL) && !pend_r && !cycBusy && !resetAccept;

    // main sequencer: reset pin, command writes, wait, status polling
    always_comb begin
        st_nxt = st_r;
        cmd_nxt = cmd_r;
        cnt_nxt = cnt_r;
        to_nxt = to_r;
        step_nxt = step_r;
        pend_nxt = pend_r;
        alg_nxt = alg_r;
        prevQ6_nxt = prevQ6_r;
        havePrev_nxt = havePrev_r;
        resetB_nxt = resetB_r;
        byteB_nxt = byteB_r;
        rspValid_nxt = 1'b0;
        rsp_nxt = rsp_r;
        if (cycStart) begin
            pend_nxt = 1'b1;
        end
        unique case (st_r)
            S_RLOW: begin
                if (cnt_r <= 32'h1) begin
                    st_nxt = S_RWAIT;
                    resetB_nxt = 1'b1;
                    cnt_nxt = alg_r ? 32'(RST_ACTIVE_CYC - RST_PULSE_CYC)
                                    : 32'(RST_HIGH_CYC);
                    alg_nxt = 1'b0;
                end else begin
                    cnt_nxt = cnt_r - 32'h1;
                end
            end
            S_RWAIT: begin
                if (cnt_r <= 32'h1) begin
                    st_nxt = S_IDLE;
                    rspValid_nxt = (cmd_r.op == OP_RESET);
                    rsp_nxt = '{data: '0, timeout: 1'b0};
                end else begin
                    cnt_nxt = cnt_r - 32'h1;
                end
            end
            S_IDLE: begin
                if (cmdValid) begin
                    cmd_nxt = cmdIn;
                    step_nxt = 3'h0;
                    byteB_nxt = cmdIn.wordMode;
                    if (cmdIn.op == OP_RESET) begin
                        st_nxt = S_RLOW;
                        resetB_nxt = 1'b0;
                        cnt_nxt = 32'(RST_PULSE_CYC);
                    end else begin
                        st_nxt = S_SEQ;
                    end
                end
            end
            S_SEQ: begin
                if (cycDone) begin
                    pend_nxt = 1'b0;
                    step_nxt = step_r + 3'h1;
                    if (step_r == lastStep(cmd_r.op)) begin
                        to_nxt = '0;
                        havePrev_nxt = 1'b0;
                        if (cmd_r.op == OP_PROGRAM) begin
                            st_nxt = S_ALG;
                            alg_nxt = 1'b1;
                            cnt_nxt = cmd_r.wordMode ? 32'(PROG_WORD_CYC)
                                                     : 32'(PROG_BYTE_CYC);
                        end else if (cmd_r.op == OP_CHIP_ERASE || cmd_r.op == OP_SECTOR_ERASE) begin
                            st_nxt = S_ALG;
                            alg_nxt = 1'b1;
                            cnt_nxt = 32'(ERASE_WAIT_CYC);
                        end else begin
                            st_nxt = S_IDLE;
                            rspValid_nxt = 1'b1;
                            rsp_nxt = '{data: rdData, timeout: 1'b0};
                        end
                    end
                end
            end
            S_ALG, S_POLL: begin
                to_nxt = to_r + 32'h1;
                if (st_r == S_ALG && cnt_r > 32'h1) begin
                    cnt_nxt = cnt_r - 32'h1;
                end else if (st_r == S_ALG) begin
                    st_nxt = S_POLL;
                end
                if (resetAccept) begin
                    cmd_nxt = cmdIn;
                    st_nxt = S_RLOW;
                    resetB_nxt = 1'b0;
                    cnt_nxt = 32'(RST_PULSE_CYC);
                end else if (cycDone) begin
                    pend_nxt = 1'b0;
                    prevQ6_nxt = rdData[6];
                    havePrev_nxt = 1'b1;
                    if (pollDone || to_r >= 32'(TIMEOUT_CYC)) begin
                        st_nxt = S_IDLE;
                        alg_nxt = 1'b0;
                        rspValid_nxt = 1'b1;
                        rsp_nxt = '{data: rdData, timeout: !pollDone};
                    end
                end
            end
        endcase
    end

    // sequencer registers; the reset pin starts asserted as if an algorithm ran
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= S_RLOW;
            cmd_r <= '0;
            cnt_r <= 32'(RST_PULSE_CYC);
            to_r <= '0;
            step_r <= '0;
            pend_r <= 1'b0;
            alg_r <= 1'b1;
            prevQ6_r <= 1'b0;
            havePrev_r <= 1'b0;
            resetB_r <= 1'b0;
            byteB_r <= 1'b1;
            rspValid_r <= 1'b0;
            rsp_r <= '0;
        end else begin
            st_r <= st_nxt;
            cmd_r <= cmd_nxt;
            cnt_r <= cnt_nxt;
            to_r <= to_nxt;
            step_r <= step_nxt;
            pend_r <= pend_nxt;
            alg_r <= alg_nxt;
            prevQ6_r <= prevQ6_nxt;
            havePrev_r <= havePrev_nxt;
            resetB_r <= resetB_nxt;
            byteB_r <= byteB_nxt;
            rspValid_r <= rspValid_nxt;
            rsp_r <= rsp_nxt;
        end
    end

    // helper counters for strobe widths, read only by assertions
    logic [19:0] weLowCnt_r, ceLowCnt_r;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            weLowCnt_r <= '0;
            ceLowCnt_r <= '0;
        end else begin
            weLowCnt_r <= busPins.weB ? 20'h00000 : weLowCnt_r + 20'h00001;
            ceLowCnt_r <= busPins.ceB ? 20'h00000 : ceLowCnt_r + 20'h00001;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence resetReleased;
        $rose(flashPins.resetB);
    endsequence

    a_reset_pulse_min: assert property ($fell(flashPins.resetB) |-> !flashPins.resetB [*5])
        else $error("reset pin pulse too short");
    a_release_to_read: assert property (resetReleased |-> flashPins.bus.oeB && !cmdReady)
        else $error("read started too soon after reset release");
    a_abort_recover: assert property (resetReleased and $past(alg_r) |-> !cmdReady [*8])
        else $error("abort reset recovery too short");
    a_protect_pulse: assert property ($rose(busPins.weB) && cmd_r.op == OP_PROTECT
        |-> weLowCnt_r >= 20'(PROT_PULSE_MIN_CYC) && weLowCnt_r == 20'(PROT_PULSE_CYC))
        else $error("protect pulse width wrong");
    a_unprotect_pulse: assert property ($rose(busPins.weB) && cmd_r.op == OP_UNPROTECT
        |-> weLowCnt_r == 20'(UNPROT_CYC))
        else $error("unprotect pulse width wrong");
    a_oe_setup: assert property ($fell(busPins.weB) && st_r == S_SEQ
        && (cmd_r.op == OP_PROTECT || cmd_r.op == OP_UNPROTECT)
        |-> ceLowCnt_r >= 20'(OE_SETUP_CYC) && busPins.oeB)
        else $error("output enable setup before write too short");
    a_poll_data: assert property (st_r == S_POLL && cycDone && !cmd_r.useToggle
        && rdData[7] == expect7 && !resetAccept |=> rspValid_r && !rsp_r.timeout
        && st_r == S_IDLE)
        else $error("data polling missed completion");
    a_poll_toggle: assert property (st_r == S_POLL && cycDone && cmd_r.useToggle
        && havePrev_r && rdData[6] != prevQ6_r && to_r < 32'(TIMEOUT_CYC)
        && !resetAccept |=> !rspValid_r ##1 st_r == S_POLL)
        else $error("toggle polling ended while bit still toggling");
endmodule
`default_nettype wire

// file: bench/hfs_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module hfs_flash_model
    import hfs_pkg::*;
#(
    parameter int ERASE_CYC = 80
) (
    input wire logic clk_sys,
    input wire hfs_pins_t flashPins,
    output logic [DATA_W-1:0] flashDataIn,
    output logic devBusy
);
    logic [DATA_W-1:0] mem [int];
    int busyCnt = 0;
    int step = 0;
    logic isErase = 1'b0;
    logic togl = 1'b0;
    logic junk = 1'b0;
    logic weLast = 1'b1;
    logic oeLast = 1'b1;
    logic [DATA_W-1:0] pgmData = '0;
    logic [DATA_W-1:0] wd;
    logic [ADDR_W-1:0] wa;

    assign devBusy = busyCnt != 0;

    // released bus shows a pattern that flips every cycle
    always @(posedge clk_sys) junk <= ~junk;

    // command decode, embedded algorithm timer and toggle bit
    always @(posedge clk_sys or negedge flashPins.resetB) begin
        if (!flashPins.resetB) begin
            busyCnt <= 0;
            step <= 0;
        end else begin
            weLast <= flashPins.bus.weB;
            oeLast <= flashPins.bus.oeB;
            if (busyCnt != 0) busyCnt <= busyCnt - 1;
            if (busyCnt != 0 && oeLast === 1'b0 && flashPins.bus.oeB === 1'b1) togl <= ~togl;
            if (weLast === 1'b0 && flashPins.bus.weB === 1'b1 && flashPins.bus.ceB === 1'b0
                && busyCnt == 0) begin
                wa = flashPins.bus.addr;
                wd = flashPins.bus.dOut;
                step <= 0;
                case (step)
                    0, 3: if (wd[7:0] == UNLOCK_DATA1[7:0]) step <= step + 1;
                    1, 4: if (wd[7:0] == UNLOCK_DATA2[7:0]) step <= step + 1;
                    2: step <= wd[7:0] == CMD_PROGRAM[7:0] ? 6 : (wd[7:0] == CMD_ERASE[7:0] ? 3 : 0);
                    5: if (wd[7:0] == CMD_CHIP[7:0] || wd[7:0] == CMD_SECTOR[7:0]) begin
                        foreach (mem[k]) if (wd[7:0] == CMD_CHIP[7:0] ||
                            k[SECTOR_LSB +: SECTOR_W] == wa[SECTOR_LSB +: SECTOR_W]) mem[k] = 16'hFFFF;
                        isErase <= 1'b1;
                        busyCnt <= ERASE_CYC;
                    end
                    6: begin
                        mem[wa] = (mem.exists(wa) ? mem[wa] : 16'hFFFF) & wd;
                        pgmData <= wd;
                        isErase <= 1'b0;
                        // runs past the typical time so the host sees busy status reads
                        busyCnt <= (flashPins.byteB ? PROG_WORD_CYC : PROG_BYTE_CYC) + 20;
                    end
                    default: step <= 0;
                endcase
            end
        end
    end

    // data bus: status while busy, array data when idle
    always @* begin
        if (flashPins.bus.ceB !== 1'b0 || flashPins.bus.oeB !== 1'b0 || !flashPins.resetB)
            flashDataIn = {DATA_W/2{junk, ~junk}};
        else if (busyCnt != 0)
            flashDataIn = {8'h00, isErase ? 1'b0 : ~pgmData[7], togl, 6'h00};
        else
            flashDataIn = mem.exists(flashPins.bus.addr) ? mem[flashPins.bus.addr] : 16'hFFFF;
    end
endmodule
`default_nettype wire

// file: bench/test_flash_embedded_algorithm_status.sv
`timescale 1ns/1ps
`default_nettype none
module test_flash_embedded_algorithm_status;
    import hfs_pkg::*;
    localparam int DEV_ERASE = 80;
    logic clk_sys, rst_b, cmdValid, cmdReady, rspValid_r, busy, devBusy;
    hfs_cmd_t cmdIn;
    hfs_rsp_t rsp_r, rsp;
    hfs_pins_t flashPins;
    logic [DATA_W-1:0] flashDataIn;
    int err_count, n_compared, cyc, rl, lastRl, weLow, lastWeLow, setup, lastSetup, sinceRst, early;

    hfs_host_ctrl #(.ERASE_WAIT_CYC(50), .UNPROT_CYC(20), .TIMEOUT_CYC(2000)) u_hfs_host_ctrl (
        .clk_sys(clk_sys), .rst_b(rst_b), .cmdValid(cmdValid), .cmdReady(cmdReady),
        .cmdIn(cmdIn), .rspValid_r(rspValid_r), .rsp_r(rsp_r), .busy(busy),
        .flashPins(flashPins), .flashDataIn(flashDataIn));
    hfs_flash_model #(.ERASE_CYC(DEV_ERASE)) u_hfs_flash_model (
        .clk_sys(clk_sys), .flashPins(flashPins), .flashDataIn(flashDataIn), .devBusy(devBusy));

    // clock generator
    initial begin
        clk_sys = 1'b0;
        forever #(CLK_NS / 2) clk_sys = ~clk_sys;
    end

    // pin timing monitor: reset width, read after reset, write setup and pulse
    always @(posedge clk_sys) begin
        if (flashPins.resetB === 1'b0) begin
            rl <= rl + 1;
            sinceRst <= 0;
        end else begin
            if (rl != 0) lastRl <= rl;
            rl <= 0;
            sinceRst <= sinceRst + 1;
            if (flashPins.bus.oeB === 1'b0 && sinceRst < RST_HIGH_CYC) early <= 1;
        end
        if (flashPins.bus.weB === 1'b0) weLow <= weLow + 1;
        else if (weLow != 0) lastWeLow <= weLow;
        if (flashPins.bus.weB !== 1'b0) weLow <= 0;
        if (flashPins.bus.ceB !== 1'b0) setup <= 0;
        else if (flashPins.bus.weB === 1'b1 && flashPins.bus.oeB === 1'b1) setup <= setup + 1;
        else if (setup != 0) lastSetup <= setup;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        if (err_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic send(input hfs_op_t op, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input logic wm, input logic tg);
        int n;
        n = 0;
        @(negedge clk_sys);
        cmdValid = 1'b1;
        cmdIn = '{op, a, d, wm, tg};
        #1;
        while (cmdReady !== 1'b1 && n < 3000) begin
            @(negedge clk_sys);
            #1;
            n++;
        end
        @(negedge clk_sys);
        cmdValid = 1'b0;
        cyc = 0;
    endtask

    task automatic wait_rsp(input int lim);
        while (rspValid_r !== 1'b1 && cyc < lim) begin
            @(posedge clk_sys);
            #1;
            cyc++;
        end
        chk("rspValid", rspValid_r, 1'b1);
        rsp = rsp_r;
    endtask

    task automatic cmd(input hfs_op_t op, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input logic wm, input logic tg);
        send(op, a, d, wm, tg);
        wait_rsp(3000);
    endtask

    task automatic test_program();
        cmd(OP_PROGRAM, 20'h01234, 16'h005A, 1'b0, 1'b0);
        chk("prgByteData", rsp.data[7:0], 8'h5A);
        chk("prgByteTime", cyc >= PROG_BYTE_CYC, 1'b1);
        chk("prgByteTo", rsp.timeout, 1'b0);
        cmd(OP_PROGRAM, 20'h21000, 16'hA5C3, 1'b1, 1'b1);
        chk("prgWordData", rsp.data, 16'hA5C3);
        chk("prgWordTime", cyc >= PROG_WORD_CYC, 1'b1);
        cmd(OP_READ, 20'h01234, 16'h0000, 1'b0, 1'b0);
        chk("readBack", rsp.data[7:0], 8'h5A);
    endtask

    task automatic test_erase();
        cmd(OP_SECTOR_ERASE, 20'h21000, 16'h0000, 1'b1, 1'b0);
        chk("seTime", cyc >= DEV_ERASE, 1'b1);
        chk("seTo", rsp.timeout, 1'b0);
        cmd(OP_READ, 20'h21000, 16'h0000, 1'b1, 1'b0);
        chk("seErased", rsp.data, 16'hFFFF);
        cmd(OP_READ, 20'h01234, 16'h0000, 1'b1, 1'b0);
        chk("seKept", rsp.data[7:0], 8'h5A);
        cmd(OP_CHIP_ERASE, 20'h00000, 16'h0000, 1'b1, 1'b1);
        chk("ceTime", cyc >= DEV_ERASE, 1'b1);
        cmd(OP_READ, 20'h01234, 16'h0000, 1'b1, 1'b0);
        chk("ceErased", rsp.data, 16'hFFFF);
    endtask

    task automatic test_reset();
        send(OP_SECTOR_ERASE, 20'h01000, 16'h0000, 1'b1, 1'b0);
        repeat (60) @(negedge clk_sys);
        send(OP_RESET, 20'h00000, 16'h0000, 1'b1, 1'b0);
        wait_rsp(400);
        chk("abortTime", cyc <= RST_ACTIVE_CYC + 10, 1'b1);
        chk("abortPulse", lastRl >= RST_PULSE_CYC, 1'b1);
        chk("devIdle", devBusy, 1'b0);
        cmd(OP_RESET, 20'h00000, 16'h0000, 1'b1, 1'b0);
        chk("idleRstTime", cyc <= RST_IDLE_CYC + 5, 1'b1);
    endtask

    task automatic test_protect();
        cmd(OP_PROTECT, 20'h03000, 16'h0000, 1'b1, 1'b0);
        chk("protSetup", lastSetup >= OE_SETUP_CYC, 1'b1);
        chk("protPulse", lastWeLow >= PROT_PULSE_MIN_CYC, 1'b1);
        cmd(OP_UNPROTECT, 20'h03000, 16'h0000, 1'b1, 1'b0);
        chk("unprotSetup", lastSetup >= OE_SETUP_CYC, 1'b1);
        chk("unprotPulse", lastWeLow >= PROT_PULSE_MIN_CYC, 1'b1);
    endtask

    // main sequence
    initial begin
        rst_b = 1'b0;
        cmdValid = 1'b0;
        cmdIn = '0;
        repeat (8) @(negedge clk_sys);
        chk("pinsInReset", {flashPins.bus.ceB, flashPins.bus.weB, flashPins.bus.dOe,
            flashPins.resetB, cmdReady, busy, flashPins.byteB}, 7'b1100011);
        rst_b = 1'b1;
        test_program();
        test_erase();
        test_reset();
        test_protect();
        chk("earlyRead", early, 0);
        stop_test();
    end

    // watchdog
    initial begin
        #(20000 * CLK_NS);
        err_count++;
        stop_test();
    end
endmodule
`default_nettype wire
